// ---- verilog/dcr_pkg.sv ----
// Package for the drive communication register bank: addresses, codes, limits and carriers.
// Assumes a protocol front end that hands over one decoded 16-bit register access at a time.
package dcr_pkg;
	localparam logic [15:0] ADDR_RUN_CMD = 16'h2000;
	localparam logic [15:0] ADDR_FREQ_SET = 16'h2001;
	localparam logic [15:0] ADDR_LOOP_SET = 16'h2002;
	localparam logic [15:0] ADDR_LOOP_FB = 16'h2003;
	localparam logic [15:0] ADDR_TORQUE_SET = 16'h2004;
	localparam logic [15:0] ADDR_FWD_LIMIT = 16'h2005;
	localparam logic [15:0] ADDR_REV_LIMIT = 16'h2006;
	localparam logic [15:0] ADDR_MOT_TORQUE = 16'h2007;
	localparam logic [15:0] ADDR_BRK_TORQUE = 16'h2008;
	localparam logic [15:0] ADDR_SPECIAL = 16'h2009;
	localparam logic [15:0] ADDR_VIN = 16'h200a;
	localparam logic [15:0] ADDR_VOUT = 16'h200b;
	localparam logic [15:0] ADDR_VOLT_SET = 16'h200c;
	localparam logic [15:0] ADDR_AO_ONE = 16'h200d;
	localparam logic [15:0] ADDR_AO_TWO = 16'h200e;
	localparam logic [15:0] ADDR_RUN_STATE = 16'h2100;
	localparam logic [15:0] ADDR_STATUS = 16'h2101;
	localparam logic [7:0] FACTORY_RESERVED_GROUP = 8'h63;
	localparam int RAM_ONLY_BIT = 15;
	localparam logic [15:0] RUN_CODE_MIN = 16'h0001;
	localparam logic [15:0] RUN_CODE_MAX = 16'h0008;
	localparam logic [15:0] PCT_FULL = 16'h03e8;
	localparam logic [15:0] TORQUE_FULL = 16'h0bb8;
	localparam logic [15:0] VIN_MAX = 16'h03ff;
	localparam logic [15:0] VOUT_MAX = 16'h000f;
	localparam logic [15:0] SPECIAL_MAX = 16'h003f;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam int SPC_MOTOR_LSB = 0;
	localparam int SPC_SWITCH = 2;
	localparam int SPC_CLR_ENERGY = 3;
	localparam int SPC_PREEXCITE = 4;
	localparam int SPC_DC_BRAKE = 5;

	typedef enum logic [3:0] {
		DCR_CMD_NONE = 4'h0,
		DCR_CMD_FWD_RUN = 4'h1,
		DCR_CMD_REV_RUN = 4'h2,
		DCR_CMD_FWD_JOG = 4'h3,
		DCR_CMD_REV_JOG = 4'h4,
		DCR_CMD_STOP = 4'h5,
		DCR_CMD_COAST = 4'h6,
		DCR_CMD_FAULT_RST = 4'h7,
		DCR_CMD_JOG_STOP = 4'h8
	} dcr_cmd_t;

	typedef enum logic [2:0] {
		DCR_RESP_OK = 3'h0,
		DCR_RESP_BAD_ADDR = 3'h1,
		DCR_RESP_READ_ONLY = 3'h2,
		DCR_RESP_BUSY = 3'h3,
		DCR_RESP_RANGE = 3'h4
	} dcr_resp_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] data;
	} dcr_req_t;

	typedef struct packed {
		logic valid;
		dcr_resp_t resp;
		logic [15:0] data;
	} dcr_ans_t;

	typedef struct packed {
		logic [15:0] writeData;
		logic nvCommit;
		logic strobe;
		logic [15:0] addr;
	} dcr_par_t;

	typedef struct packed {
		logic [2:0] runState;
		logic readyToRun;
		logic [1:0] activeMotor;
		logic syncMotor;
		logic overloadAlarm;
		logic [1:0] controlSource;
	} dcr_stat_t;
endpackage

// ---- verilog/dcr_register_bank.sv ----
// Register bank of the drive communication interface, one 16-bit access per request.
// Assumes the fieldbus front end strips framing and CRC and presents a single-cycle request;
// the parameter store answers reads through parRdData with its per-parameter lock flags.
`timescale 1ns/100ps
`default_nettype none
module dcr_register_bank #(
	parameter logic [15:0] MAX_FREQ = 16'h4e20
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire dcr_pkg::dcr_req_t req,
	output dcr_pkg::dcr_ans_t ans,
	input wire logic motorRunning,
	input wire logic parLockRun,
	input wire logic parLockAlways,
	input wire logic parExists,
	input wire logic [15:0] parRdData,
	input wire dcr_pkg::dcr_stat_t status,
	output dcr_pkg::dcr_par_t parWrite,
	output dcr_pkg::dcr_cmd_t runCommand,
	output logic runCommandPulse,
	output logic [15:0] frequencySetpoint,
	output logic [15:0] loopSetpoint,
	output logic [15:0] loopFeedback,
	output logic [15:0] torqueSetpoint,
	output logic [15:0] forwardFreqLimit,
	output logic [15:0] reverseFreqLimit,
	output logic [15:0] motoringTorqueLimit,
	output logic [15:0] brakingTorqueLimit,
	output logic [5:0] specialControl,
	output logic [9:0] virtualInputs,
	output logic [3:0] virtualOutputs,
	output logic [15:0] separatedVoltageSetpoint,
	output logic [15:0] analogOutSetpointOne,
	output logic [15:0] analogOutSetpointTwo
);
	// Signed window check used by every signed setpoint.
	function automatic logic in_signed(input logic [15:0] v, input logic [15:0] lim);
		in_signed = ($signed(v) <= $signed(lim)) && ($signed(v) >= -$signed(lim));
	endfunction

	wire logic [15:0] a = req.addr;
	wire logic ramOnly = a[dcr_pkg::RAM_ONLY_BIT];
	wire logic [7:0] group = {1'b0, a[14:8]};
	wire logic isCtrl = (a >= dcr_pkg::ADDR_RUN_CMD) && (a <= dcr_pkg::ADDR_AO_TWO);
	wire logic isStat = (a == dcr_pkg::ADDR_RUN_STATE) || (a == dcr_pkg::ADDR_STATUS);
	// Matching bits 14:8 as well keeps the working-copy alias of the reserved group refused.
	wire logic isReserved = ({ramOnly, a[14:8]} == dcr_pkg::FACTORY_RESERVED_GROUP) ||
		(group == dcr_pkg::FACTORY_RESERVED_GROUP);
	wire logic isParam = !isCtrl && !isStat && !isReserved && parExists;
	wire logic [15:0] d = req.data;
	wire logic doWrite = req.valid && req.write;
	wire logic doRead = req.valid && !req.write;

	logic rangeOk;
	always_comb begin
		if (a == dcr_pkg::ADDR_RUN_CMD) begin
			rangeOk = (d >= dcr_pkg::RUN_CODE_MIN) && (d <= dcr_pkg::RUN_CODE_MAX);
		end else if (a == dcr_pkg::ADDR_FREQ_SET || a == dcr_pkg::ADDR_FWD_LIMIT ||
			a == dcr_pkg::ADDR_REV_LIMIT) begin
			rangeOk = d <= MAX_FREQ;
		end else if (a == dcr_pkg::ADDR_LOOP_SET || a == dcr_pkg::ADDR_LOOP_FB ||
			a == dcr_pkg::ADDR_VOLT_SET) begin
			rangeOk = d <= dcr_pkg::PCT_FULL;
		end else if (a == dcr_pkg::ADDR_TORQUE_SET) begin
			rangeOk = in_signed(d, dcr_pkg::TORQUE_FULL);
		end else if (a == dcr_pkg::ADDR_MOT_TORQUE || a == dcr_pkg::ADDR_BRK_TORQUE) begin
			rangeOk = d <= dcr_pkg::TORQUE_FULL;
		end else if (a == dcr_pkg::ADDR_SPECIAL) begin
			rangeOk = d <= dcr_pkg::SPECIAL_MAX;
		end else if (a == dcr_pkg::ADDR_VIN) begin
			rangeOk = d <= dcr_pkg::VIN_MAX;
		end else if (a == dcr_pkg::ADDR_VOUT) begin
			rangeOk = d <= dcr_pkg::VOUT_MAX;
		end else if (a == dcr_pkg::ADDR_AO_ONE || a == dcr_pkg::ADDR_AO_TWO) begin
			rangeOk = in_signed(d, dcr_pkg::PCT_FULL);
		end else begin
			rangeOk = 1'b1;
		end
	end

	// Control registers sit at fixed addresses; the alias bit applies only to parameters.
	dcr_pkg::dcr_resp_t next_resp;
	always_comb begin
		if (isReserved) begin
			next_resp = dcr_pkg::DCR_RESP_BAD_ADDR;
		end else if (doRead && ramOnly) begin
			next_resp = dcr_pkg::DCR_RESP_BAD_ADDR;
		end else if (isStat) begin
			next_resp = req.write ? dcr_pkg::DCR_RESP_READ_ONLY : dcr_pkg::DCR_RESP_OK;
		end else if (isCtrl) begin
			next_resp = (req.write && !rangeOk) ? dcr_pkg::DCR_RESP_RANGE : dcr_pkg::DCR_RESP_OK;
		end else if (!isParam) begin
			next_resp = dcr_pkg::DCR_RESP_BAD_ADDR;
		end else if (req.write && (parLockAlways || (parLockRun && motorRunning))) begin
			next_resp = dcr_pkg::DCR_RESP_BUSY;
		end else begin
			next_resp = dcr_pkg::DCR_RESP_OK;
		end
	end

	wire logic accept = req.valid && (next_resp == dcr_pkg::DCR_RESP_OK);
	wire logic ctrlWr = accept && req.write && isCtrl;
	wire logic parWr = accept && req.write && isParam;
	wire logic runWr = ctrlWr && (a == dcr_pkg::ADDR_RUN_CMD);

	wire logic [15:0] statWord = {8'h00, 1'b0, status.controlSource, status.overloadAlarm,
		status.syncMotor, status.activeMotor, status.readyToRun};
	wire logic [15:0] runWord = {13'h0000, status.runState};

	logic [15:0] next_rdata;
	always_comb begin
		if (!accept || req.write) begin
			next_rdata = dcr_pkg::ZERO_WORD;
		end else if (a == dcr_pkg::ADDR_RUN_STATE) begin
			next_rdata = runWord;
		end else if (a == dcr_pkg::ADDR_STATUS) begin
			next_rdata = statWord;
		end else if (a == dcr_pkg::ADDR_RUN_CMD) begin
			next_rdata = {12'h000, runCommand};
		end else if (a == dcr_pkg::ADDR_FREQ_SET) begin
			next_rdata = frequencySetpoint;
		end else if (a == dcr_pkg::ADDR_LOOP_SET) begin
			next_rdata = loopSetpoint;
		end else if (a == dcr_pkg::ADDR_LOOP_FB) begin
			next_rdata = loopFeedback;
		end else if (a == dcr_pkg::ADDR_TORQUE_SET) begin
			next_rdata = torqueSetpoint;
		end else if (a == dcr_pkg::ADDR_FWD_LIMIT) begin
			next_rdata = forwardFreqLimit;
		end else if (a == dcr_pkg::ADDR_REV_LIMIT) begin
			next_rdata = reverseFreqLimit;
		end else if (a == dcr_pkg::ADDR_MOT_TORQUE) begin
			next_rdata = motoringTorqueLimit;
		end else if (a == dcr_pkg::ADDR_BRK_TORQUE) begin
			next_rdata = brakingTorqueLimit;
		end else if (a == dcr_pkg::ADDR_SPECIAL) begin
			next_rdata = {10'h000, specialControl};
		end else if (a == dcr_pkg::ADDR_VIN) begin
			next_rdata = {6'h00, virtualInputs};
		end else if (a == dcr_pkg::ADDR_VOUT) begin
			next_rdata = {12'h000, virtualOutputs};
		end else if (a == dcr_pkg::ADDR_VOLT_SET) begin
			next_rdata = separatedVoltageSetpoint;
		end else if (a == dcr_pkg::ADDR_AO_ONE) begin
			next_rdata = analogOutSetpointOne;
		end else if (a == dcr_pkg::ADDR_AO_TWO) begin
			next_rdata = analogOutSetpointTwo;
		end else begin
			next_rdata = parRdData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ans <= '0;
		end else begin
			ans.valid <= req.valid;
			ans.resp <= req.valid ? next_resp : dcr_pkg::DCR_RESP_OK;
			ans.data <= next_rdata;
		end
	end

	// Parameter writes pass through to the store; the alias suppresses the commit.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			parWrite <= '0;
		end else begin
			parWrite.strobe <= parWr;
			parWrite.addr <= {1'b0, a[14:0]};
			parWrite.nvCommit <= parWr && !ramOnly;
			parWrite.writeData <= d;
		end
	end

	// The command is held, and a one-cycle pulse marks each accepted write so repeats act.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			runCommand <= dcr_pkg::DCR_CMD_NONE;
			runCommandPulse <= 1'b0;
		end else begin
			runCommandPulse <= runWr;
			if (runWr) begin
				runCommand <= dcr_pkg::dcr_cmd_t'(d[3:0]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			frequencySetpoint <= '0;
			loopSetpoint <= '0;
			loopFeedback <= '0;
			torqueSetpoint <= '0;
			forwardFreqLimit <= '0;
			reverseFreqLimit <= '0;
			motoringTorqueLimit <= '0;
			brakingTorqueLimit <= '0;
			specialControl <= '0;
			virtualInputs <= '0;
			virtualOutputs <= '0;
			separatedVoltageSetpoint <= '0;
			analogOutSetpointOne <= '0;
			analogOutSetpointTwo <= '0;
		end else if (ctrlWr) begin
			if (a == dcr_pkg::ADDR_FREQ_SET) begin
				frequencySetpoint <= d;
			end
			if (a == dcr_pkg::ADDR_LOOP_SET) begin
				loopSetpoint <= d;
			end
			if (a == dcr_pkg::ADDR_LOOP_FB) begin
				loopFeedback <= d;
			end
			if (a == dcr_pkg::ADDR_TORQUE_SET) begin
				torqueSetpoint <= d;
			end
			if (a == dcr_pkg::ADDR_FWD_LIMIT) begin
				forwardFreqLimit <= d;
			end
			if (a == dcr_pkg::ADDR_REV_LIMIT) begin
				reverseFreqLimit <= d;
			end
			if (a == dcr_pkg::ADDR_MOT_TORQUE) begin
				motoringTorqueLimit <= d;
			end
			if (a == dcr_pkg::ADDR_BRK_TORQUE) begin
				brakingTorqueLimit <= d;
			end
			if (a == dcr_pkg::ADDR_SPECIAL) begin
				specialControl <= d[5:0];
			end
			if (a == dcr_pkg::ADDR_VIN) begin
				virtualInputs <= d[9:0];
			end
			if (a == dcr_pkg::ADDR_VOUT) begin
				virtualOutputs <= d[3:0];
			end
			if (a == dcr_pkg::ADDR_VOLT_SET) begin
				separatedVoltageSetpoint <= d;
			end
			if (a == dcr_pkg::ADDR_AO_ONE) begin
				analogOutSetpointOne <= d;
			end
			if (a == dcr_pkg::ADDR_AO_TWO) begin
				analogOutSetpointTwo <= d;
			end
		end
	end

	a_reserved_refused: assert property (@(posedge clk) disable iff (!rst_b)
		req.valid && isReserved |=> ans.valid && ans.resp == dcr_pkg::DCR_RESP_BAD_ADDR)
		else $error("Reserved group access was not refused.");
	a_reserved_no_store: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && isReserved |=> !parWrite.strobe && !runCommandPulse)
		else $error("Reserved group write reached the store.");
	a_run_lock_write: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && isParam && !isReserved && motorRunning && parLockRun
		|=> ans.resp == dcr_pkg::DCR_RESP_BUSY && !parWrite.strobe)
		else $error("Run-locked write was not refused.");
	a_fixed_lock_write: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && isParam && parLockAlways
		|=> ans.resp == dcr_pkg::DCR_RESP_BUSY && !parWrite.strobe)
		else $error("Fixed parameter write was not refused.");
	a_alias_no_commit: assert property (@(posedge clk) disable iff (!rst_b)
		parWrite.strobe && $past(ramOnly) |-> !parWrite.nvCommit)
		else $error("Working-copy write committed to storage.");
	a_plain_commit: assert property (@(posedge clk) disable iff (!rst_b)
		parWr && !ramOnly |=> parWrite.strobe && parWrite.nvCommit)
		else $error("Plain parameter write was not committed.");
	a_param_address: assert property (@(posedge clk) disable iff (!rst_b)
		parWr |=> parWrite.addr == ($past(a) & 16'h7fff) && parWrite.writeData == $past(d))
		else $error("Parameter write carried the wrong address or data.");
	a_alias_read_bad: assert property (@(posedge clk) disable iff (!rst_b)
		doRead && ramOnly |=> ans.resp != dcr_pkg::DCR_RESP_OK && ans.data == 16'h0000)
		else $error("Alias read returned data.");
	a_run_cmd_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_RUN_CMD && rangeOk
		|=> runCommandPulse && {12'h000, runCommand} == $past(d))
		else $error("Run command not latched with a pulse.");
	a_pulse_cause: assert property (@(posedge clk) disable iff (!rst_b)
		runCommandPulse |-> $past(runWr))
		else $error("Run command pulse without an accepted write.");
	a_freq_range: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_FREQ_SET && d > MAX_FREQ
		|=> $stable(frequencySetpoint) && ans.resp == dcr_pkg::DCR_RESP_RANGE)
		else $error("Out-of-range frequency write was taken.");
	a_loop_range: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_LOOP_SET && d > dcr_pkg::PCT_FULL |=> $stable(loopSetpoint))
		else $error("Out-of-range loop setpoint write was taken.");
	a_range_keeps: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_TORQUE_SET && !rangeOk
		|=> $stable(torqueSetpoint) && ans.resp == dcr_pkg::DCR_RESP_RANGE)
		else $error("Out-of-range torque write was taken.");
	a_brake_range: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_BRK_TORQUE && d > dcr_pkg::TORQUE_FULL
		|=> $stable(brakingTorqueLimit))
		else $error("Out-of-range braking limit write was taken.");
	a_special_bits: assert property (@(posedge clk) disable iff (!rst_b)
		ctrlWr && a == dcr_pkg::ADDR_SPECIAL |=> {10'h000, specialControl} == $past(d))
		else $error("Special control word not stored.");
	a_vin_width: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_VIN && d > dcr_pkg::VIN_MAX |=> $stable(virtualInputs))
		else $error("Virtual input took an out-of-range value.");
	a_vout_width: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_VOUT && d > dcr_pkg::VOUT_MAX |=> $stable(virtualOutputs))
		else $error("Virtual output took an out-of-range value.");
	a_volt_range: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_VOLT_SET && d > dcr_pkg::PCT_FULL
		|=> $stable(separatedVoltageSetpoint))
		else $error("Out-of-range voltage setpoint write was taken.");
	a_ao_range: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && a == dcr_pkg::ADDR_AO_ONE && !in_signed(d, dcr_pkg::PCT_FULL)
		|=> $stable(analogOutSetpointOne))
		else $error("Out-of-range analog output write was taken.");
	a_run_state_read: assert property (@(posedge clk) disable iff (!rst_b)
		doRead && a == dcr_pkg::ADDR_RUN_STATE |=> ans.data == {13'h0000, $past(status.runState)})
		else $error("Run state read is wrong.");
	a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
		doRead && a == dcr_pkg::ADDR_STATUS |=> ans.data[0] == $past(status.readyToRun) &&
		ans.data[6:5] == $past(status.controlSource) && ans.data[7] == 1'b0)
		else $error("Status word read is wrong.");
	a_status_readonly: assert property (@(posedge clk) disable iff (!rst_b)
		doWrite && isStat && !isReserved |=> ans.resp == dcr_pkg::DCR_RESP_READ_ONLY)
		else $error("Status write was not refused.");
	a_unknown_refused: assert property (@(posedge clk) disable iff (!rst_b)
		req.valid && !isCtrl && !isStat && !parExists |=> ans.resp == dcr_pkg::DCR_RESP_BAD_ADDR)
		else $error("Unknown address was not refused.");
	a_refused_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		req.valid && next_resp != dcr_pkg::DCR_RESP_OK
		|=> ans.data == 16'h0000 && !parWrite.strobe && !runCommandPulse)
		else $error("Refused access changed state or returned data.");
	a_answer_follows: assert property (@(posedge clk) disable iff (!rst_b)
		ans.valid == $past(req.valid))
		else $error("Answer strobe does not follow the request.");
endmodule
`default_nettype wire

// ---- verification/dcr_param_store_model.sv ----
// Behavioural parameter store that sits behind the register bank.
// Assumes the bank presents req.addr and a one-cycle parWrite strobe.
`timescale 1ns/100ps
`default_nettype none
module dcr_param_store_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] addr,
	input wire dcr_pkg::dcr_par_t parWrite,
	output logic exists,
	output logic lockRun,
	output logic lockAlways,
	output logic [15:0] rdData
);
	logic [15:0] mem [16];
	// The reserved group exists here, so only the bank itself can refuse it.
	assign exists = (addr[14:8] < 7'h20) || (addr[14:8] == 7'h63);
	assign lockRun = addr[7:0] == 8'h10;
	assign lockAlways = addr[7:0] == 8'h11;
	// A missing parameter reads as its inverted address, never a stale word.
	assign rdData = exists ? mem[addr[3:0]] : ~addr;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem <= '{default: 16'h0000};
		end else if (parWrite.strobe) begin
			mem[parWrite.addr[3:0]] <= parWrite.writeData;
		end
	end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for the drive communication register bank.
// Assumes the parameter store model answers lock and existence flags combinationally.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [15:0] FMAX = 16'h4e20;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	dcr_pkg::dcr_req_t req = '0;
	dcr_pkg::dcr_ans_t ans;
	logic motorRunning = 1'b0;
	logic parLockRun, parLockAlways, parExists, runCommandPulse, lastPulse;
	logic [15:0] parRdData;
	dcr_pkg::dcr_stat_t status = '0;
	dcr_pkg::dcr_par_t parWrite, lastPar;
	dcr_pkg::dcr_cmd_t runCommand;
	logic [15:0] frequencySetpoint, loopSetpoint, loopFeedback, torqueSetpoint;
	logic [15:0] forwardFreqLimit, reverseFreqLimit, motoringTorqueLimit, brakingTorqueLimit;
	logic [15:0] separatedVoltageSetpoint, analogOutSetpointOne, analogOutSetpointTwo;
	logic [5:0] specialControl;
	logic [9:0] virtualInputs;
	logic [3:0] virtualOutputs;
	logic [15:0] ctlOut [14];
	logic [15:0] goodVal [14] = '{FMAX, 16'h03e8, 16'h03e8, 16'hf448, FMAX, FMAX, 16'h0bb8,
		16'h0bb8, 16'h003f, 16'h03ff, 16'h000f, 16'h03e8, 16'hfc18, 16'h03e8};
	logic [15:0] badVal [14] = '{FMAX + 16'h0001, 16'h03e9, 16'h03e9, 16'hf447, FMAX + 16'h0001,
		FMAX + 16'h0001, 16'h0bb9, 16'h0bb9, 16'h0040, 16'h0400, 16'h0010, 16'h03e9, 16'hfc17,
		16'h03e9};
	int num_errors = 0;
	int total_checks = 0;

	always_comb ctlOut = '{frequencySetpoint, loopSetpoint, loopFeedback, torqueSetpoint,
		forwardFreqLimit, reverseFreqLimit, motoringTorqueLimit, brakingTorqueLimit,
		{10'h000, specialControl}, {6'h00, virtualInputs}, {12'h000, virtualOutputs},
		separatedVoltageSetpoint, analogOutSetpointOne, analogOutSetpointTwo};

	dcr_register_bank #(.MAX_FREQ(FMAX)) dcr_register_bank_inst (.clk(clk), .rst_b(rst_b),
		.req(req), .ans(ans), .motorRunning(motorRunning), .parLockRun(parLockRun),
		.parLockAlways(parLockAlways), .parExists(parExists), .parRdData(parRdData),
		.status(status), .parWrite(parWrite), .runCommand(runCommand),
		.runCommandPulse(runCommandPulse), .frequencySetpoint(frequencySetpoint),
		.loopSetpoint(loopSetpoint), .loopFeedback(loopFeedback),
		.torqueSetpoint(torqueSetpoint), .forwardFreqLimit(forwardFreqLimit),
		.reverseFreqLimit(reverseFreqLimit), .motoringTorqueLimit(motoringTorqueLimit),
		.brakingTorqueLimit(brakingTorqueLimit), .specialControl(specialControl),
		.virtualInputs(virtualInputs), .virtualOutputs(virtualOutputs),
		.separatedVoltageSetpoint(separatedVoltageSetpoint),
		.analogOutSetpointOne(analogOutSetpointOne), .analogOutSetpointTwo(analogOutSetpointTwo));

	dcr_param_store_model dcr_param_store_model_inst (.clk(clk), .rst_b(rst_b),
		.addr(req.addr), .parWrite(parWrite), .exists(parExists), .lockRun(parLockRun),
		.lockAlways(parLockAlways), .rdData(parRdData));

	always #20 clk = ~clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One request, then the answer is judged one edge later while it stands.
	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
		input logic [2:0] expResp, input logic [15:0] expData);
		@(posedge clk);
		req <= '{valid: 1'b1, write: wr, addr: addr, data: wdata};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		lastPar = parWrite;
		lastPulse = runCommandPulse;
		chk({12'h000, ans.valid, ans.resp}, {12'h000, 1'b1, expResp});
		chk(ans.data, expData);
	endtask

	task automatic t_reset;
		chk({12'h000, runCommand}, 16'h0000);
		for (int i = 0; i < 14; i++) begin
			chk(ctlOut[i], 16'h0000);
		end
	endtask

	task automatic t_run;
		for (int c = 1; c <= 8; c++) begin
			access(1'b1, dcr_pkg::ADDR_RUN_CMD, c[15:0], 3'h0, 16'h0000);
			chk({12'h000, runCommand}, c[15:0]);
			chk({15'h0000, lastPulse}, 16'h0001);
		end
		access(1'b1, dcr_pkg::ADDR_RUN_CMD, 16'h0009, 3'h4, 16'h0000);
		access(1'b1, dcr_pkg::ADDR_RUN_CMD, 16'h0000, 3'h4, 16'h0000);
		chk({12'h000, runCommand}, 16'h0008);
		chk({15'h0000, lastPulse}, 16'h0000);
	endtask

	// Each setpoint takes its bound and refuses one step beyond it.
	task automatic t_setpoints;
		logic [15:0] a;
		for (int i = 0; i < 14; i++) begin
			a = dcr_pkg::ADDR_FREQ_SET + i[15:0];
			access(1'b1, a, goodVal[i], 3'h0, 16'h0000);
			access(1'b1, a, badVal[i], 3'h4, 16'h0000);
			chk(ctlOut[i], goodVal[i]);
			access(1'b0, a, 16'h0000, 3'h0, goodVal[i]);
		end
	endtask

	task automatic t_status;
		@(posedge clk);
		status <= '{3'h5, 1'b1, 2'h1, 1'b1, 1'b0, 2'h2};
		access(1'b0, dcr_pkg::ADDR_RUN_STATE, 16'h0000, 3'h0, 16'h0005);
		access(1'b0, dcr_pkg::ADDR_STATUS, 16'h0000, 3'h0, 16'h004b);
		@(posedge clk);
		status <= '{3'h6, 1'b0, 2'h0, 1'b0, 1'b1, 2'h1};
		access(1'b0, dcr_pkg::ADDR_STATUS, 16'h0000, 3'h0, 16'h0030);
		access(1'b1, dcr_pkg::ADDR_STATUS, 16'h00ff, 3'h2, 16'h0000);
		access(1'b0, dcr_pkg::ADDR_STATUS, 16'h0000, 3'h0, 16'h0030);
	endtask

	task automatic t_params;
		access(1'b1, 16'h0506, 16'h1234, 3'h0, 16'h0000);
		chk(lastPar.addr, 16'h0506);
		chk({lastPar.strobe, lastPar.nvCommit, 14'h0000}, 16'hc000);
		chk(lastPar.writeData, 16'h1234);
		access(1'b0, 16'h0506, 16'h0000, 3'h0, 16'h1234);
		access(1'b1, 16'h8007, 16'h0bcd, 3'h0, 16'h0000);
		chk(lastPar.addr, 16'h0007);
		chk({lastPar.strobe, lastPar.nvCommit, 14'h0000}, 16'h8000);
		access(1'b0, 16'h8007, 16'h0000, 3'h1, 16'h0000);
		access(1'b0, 16'h6300, 16'h0000, 3'h1, 16'h0000);
		access(1'b1, 16'h6301, 16'h0001, 3'h1, 16'h0000);
		chk({15'h0000, lastPar.strobe}, 16'h0000);
		access(1'b1, 16'he301, 16'h0001, 3'h1, 16'h0000);
		chk({15'h0000, lastPar.strobe}, 16'h0000);
		access(1'b1, 16'h3000, 16'h0001, 3'h1, 16'h0000);
		@(posedge clk);
		motorRunning <= 1'b1;
		access(1'b1, 16'h0110, 16'h0005, 3'h3, 16'h0000);
		access(1'b1, 16'h0111, 16'h0005, 3'h3, 16'h0000);
		access(1'b1, 16'h0506, 16'h0005, 3'h0, 16'h0000);
		@(posedge clk);
		motorRunning <= 1'b0;
		access(1'b1, 16'h0110, 16'h0005, 3'h0, 16'h0000);
		access(1'b1, 16'h0111, 16'h0005, 3'h3, 16'h0000);
	endtask

	// Sixteen back-to-back words, as a continuous write reaches the bank.
	task automatic t_burst;
		for (int i = 0; i <= 16; i++) begin
			@(posedge clk);
			if (i < 16) begin
				req <= '{1'b1, 1'b1, 16'h0100 + i[15:0], 16'ha000 + i[15:0]};
			end else begin
				req.valid <= 1'b0;
			end
			#1;
			if (i > 0) begin
				chk({12'h000, ans.valid, ans.resp}, 16'h0008);
			end
		end
		access(1'b0, 16'h010f, 16'h0000, 3'h0, 16'ha00f);
	endtask

	task automatic finish_test;
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		t_reset();
		t_run();
		t_setpoints();
		t_status();
		t_params();
		t_burst();
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		$display("Watchdog expired at %0t", $time);
		finish_test();
	end
endmodule
`default_nettype wire
